// ==== hdl/llc_guard.sv ====
module llc_guard (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input wire logic [11:0] load_i,
	input wire logic load_valid_i,
	input wire logic [11:0] shed_thr_i,
	input wire logic [11:0] burst_thr_i,
	input wire logic [11:0] dump_slope_i,
	input wire logic [1:0][15:0] period_i,
	input wire logic [7:0] dead_i,
	input wire logic [1:0] tank_pos_i,
	output logic [1:0] gate_hi_o,
	output logic [1:0] gate_lo_o,
	output logic sr_dump_o,
	output logic phase2_on_o,
	output logic running_o,
	output logic cap_fault_o
);
	llc_pkg::seq_t state;
	llc_pkg::seq_t next_state;
	logic [1:0] step;
	logic [1:0] next_step;
	logic [15:0] pause;
	logic [15:0] next_pause;
	logic shed;
	logic next_shed;
	logic burst_off;
	logic next_burst;
	logic [15:0] trim;
	logic [15:0] next_trim;
	logic [9:0] decay;
	logic [9:0] next_decay;
	logic [15:0] dump;
	logic [15:0] next_dump;
	logic [11:0] prev_load;
	logic [11:0] next_prev;
	logic [1:0] en;
	logic [1:0] next_en;
	logic next_fault;
	logic next_run;
	logic low_load;
	logic starting;
	logic [1:0] zc;
	logic [1:0] near;
	logic [1:0] capv;

	pwm_if pw[2] ();

	always_comb begin
		next_state = state;
		next_step = step;
		next_pause = pause;
		next_burst = burst_off;
		next_decay = decay + 10'h001;
		next_prev = prev_load;
		next_dump = dump;
		next_trim = trim;
		next_shed = shed;
		low_load = load_i < burst_thr_i;
		starting = state == llc_pkg::STEP1 || state == llc_pkg::STEP2 ||
			state == llc_pkg::STEP3 || state == llc_pkg::STEP4;
		unique case (state)
			llc_pkg::IDLE: begin
				if (start_i) begin
					next_state = llc_pkg::STEP1;
					next_step = 2'h0;
				end
			end
			llc_pkg::STEP1, llc_pkg::STEP2, llc_pkg::STEP3, llc_pkg::STEP4: begin
				if (zc[0]) begin
					if (step == 2'(llc_pkg::STEP_ZC - 1)) begin
						next_step = 2'h0;
						unique case (state)
							llc_pkg::STEP1: next_state = llc_pkg::STEP2;
							llc_pkg::STEP2: next_state = llc_pkg::STEP3;
							llc_pkg::STEP3: next_state = llc_pkg::STEP4;
							default: next_state = llc_pkg::RUN;
						endcase
					end else begin
						next_step = step + 2'h1;
					end
				end
			end
			llc_pkg::RUN: begin
				if (!start_i) begin
					next_state = llc_pkg::IDLE;
				end
			end
			llc_pkg::PAUSE: begin
				if (pause == 16'h0000) begin
					next_state = llc_pkg::IDLE;
				end else begin
					next_pause = pause - 16'h0001;
				end
			end
			default: next_state = llc_pkg::IDLE;
		endcase
		if (state != llc_pkg::IDLE && state != llc_pkg::PAUSE && |capv) begin
			next_state = llc_pkg::PAUSE;
			next_pause = 16'(llc_pkg::PAUSE_CYC - 1);
		end
		// leaving burst waits on no crossing: an idle tank has none
		if (burst_off) begin
			next_burst = state == llc_pkg::RUN && low_load;
		end else if (zc[0]) begin
			next_burst = state == llc_pkg::RUN && low_load;
		end
		if (load_valid_i) begin
			next_shed = load_i < shed_thr_i;
			next_prev = load_i;
			if (prev_load > load_i && prev_load - load_i > dump_slope_i) begin
				next_dump = 16'(llc_pkg::DUMP_CYC);
			end else if (dump != 16'h0000) begin
				next_dump = dump - 16'h0001;
			end
		end else if (dump != 16'h0000) begin
			next_dump = dump - 16'h0001;
		end
		if (next_state != llc_pkg::RUN) begin
			next_shed = 1'b0;
		end
		// trim shortens the period, it never lengthens it past nominal
		if (|near) begin
			if (trim <= llc_pkg::TRIM_MAX - llc_pkg::TRIM_STEP) begin
				next_trim = trim + llc_pkg::TRIM_STEP;
			end
		end else if (decay == 10'h000 && trim != 16'h0000) begin
			next_trim = trim - llc_pkg::TRIM_STEP;
		end
		if (state == llc_pkg::IDLE) begin
			next_trim = 16'h0000;
		end
		next_en[0] = next_state == llc_pkg::STEP1 ||
			next_state == llc_pkg::STEP2 || next_state == llc_pkg::STEP3 ||
			next_state == llc_pkg::STEP4 ||
			(next_state == llc_pkg::RUN && !next_burst);
		next_en[1] = next_en[0] && !next_shed;
		next_fault = next_state == llc_pkg::PAUSE;
		next_run = next_state == llc_pkg::RUN;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state <= llc_pkg::IDLE;
			step <= 2'h0;
			pause <= 16'h0000;
			shed <= 1'b0;
			burst_off <= 1'b0;
			trim <= 16'h0000;
			decay <= 10'h000;
			dump <= 16'h0000;
			prev_load <= 12'h000;
			en <= 2'h0;
			sr_dump_o <= 1'b0;
			phase2_on_o <= 1'b0;
			running_o <= 1'b0;
			cap_fault_o <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			pause <= next_pause;
			shed <= next_shed;
			burst_off <= next_burst;
			trim <= next_trim;
			decay <= next_decay;
			dump <= next_dump;
			prev_load <= next_prev;
			en <= next_en;
			sr_dump_o <= next_dump != 16'h0000;
			phase2_on_o <= next_en[1];
			running_o <= next_run;
			cap_fault_o <= next_fault;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : ph
		logic s1;
		logic s2;
		logic s3;
		logic [15:0] cnt;
		logic [15:0] next_cnt;
		logic [15:0] meas;
		logic [15:0] next_meas;
		logic armed;
		logic next_armed;
		logic mv;
		logic next_mv;
		logic signed [17:0] ps;
		logic signed [17:0] margin;

		always_comb begin
			next_cnt = cnt;
			next_meas = meas;
			next_armed = armed;
			next_mv = 1'b0;
			if (pw[g].toff) begin
				next_cnt = 16'h0000;
				next_armed = 1'b1;
			end else if (armed && zc[g]) begin
				next_meas = cnt;
				next_armed = 1'b0;
				next_mv = 1'b1;
			end else if (armed && cnt != llc_pkg::CNT_MAX) begin
				next_cnt = cnt + 16'h0001;
			end
		end

		// s1 is only seen by s2; the crossing comes from s2 against s3
		always_ff @(posedge clk_i) begin
			if (!resetn_i) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				cnt <= 16'h0000;
				meas <= 16'h0000;
				armed <= 1'b0;
				mv <= 1'b0;
			end else begin
				s1 <= tank_pos_i[g];
				s2 <= s1;
				s3 <= s2;
				cnt <= next_cnt;
				meas <= next_meas;
				armed <= next_armed;
				mv <= next_mv;
			end
		end

		assign zc[g] = s2 ^ s3;
		// phase margin scales with the period so it reads as an angle
		assign ps = signed'({2'b00, meas}) - signed'({10'h000, dead_i});
		assign margin = signed'({2'b00, period_i[g] >> llc_pkg::MARGIN_SHIFT});
		assign near[g] = mv && ps >= 0 && ps <= margin;
		assign capv[g] = mv && ps < 0;
		assign pw[g].en = en[g];
		assign pw[g].kill = capv[g];
		assign pw[g].period = period_i[g] - trim;
		assign pw[g].dead = dead_i;
		assign gate_hi_o[g] = pw[g].hi;
		assign gate_lo_o[g] = pw[g].lo;

		pwm_gen u_gen (
			.clk_i(clk_i),
			.resetn_i(resetn_i),
			.pw(pw[g])
		);
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	shed_phase_a: assert property ((state == llc_pkg::RUN && shed) |->
		!en[1]) else $error("second phase on while shed");
	step_zc_a: assert property ((starting && $past(starting) &&
		state != $past(state)) |-> $past(zc[0]))
		else $error("start-up step moved without a crossing");
	step_order_a: assert property ((state == llc_pkg::STEP1 &&
		next_state != state) |=> state inside {llc_pkg::STEP2, llc_pkg::PAUSE})
		else $error("start-up step out of order");
	dump_mode_a: assert property ((load_valid_i && prev_load > load_i &&
		prev_load - load_i > dump_slope_i) |=> sr_dump_o [*2])
		else $error("load dump not flagged");
	meas_clear_a: assert property (pw[0].toff |=> ph[0].cnt == 16'h0000)
		else $error("reversal counter not cleared at turn-off");
	cap_detect_a: assert property ((ph[0].mv && ph[0].meas <
		{8'h00, dead_i} && state == llc_pkg::RUN) |=> state == llc_pkg::PAUSE)
		else $error("negative phase not caught");
	trim_up_a: assert property ((near[0] && trim < llc_pkg::TRIM_MAX
		&& state != llc_pkg::IDLE) |=> trim == $past(trim) + llc_pkg::TRIM_STEP)
		else $error("frequency not raised at zero phase");
	cap_kill_a: assert property (capv[1] |=> !gate_hi_o[1]
		&& !gate_lo_o[1]) else $error("switch left on in capacitive mode");
	pause_off_a: assert property ((state == llc_pkg::PAUSE &&
		$past(state) == llc_pkg::PAUSE) |-> gate_hi_o == 2'h0 &&
		gate_lo_o == 2'h0) else $error("bridge switching during pause");
	resume_a: assert property (($past(state) == llc_pkg::PAUSE &&
		state != llc_pkg::PAUSE) |-> state == llc_pkg::IDLE)
		else $error("resumed without start-up");
endmodule

// ==== hdl/llc_pkg.sv ====
package llc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int PAUSE_NS = 20000;
	localparam int PAUSE_CYC = (PAUSE_NS * CLK_MHZ + 999) / 1000;
	localparam int DUMP_NS = 10000;
	localparam int DUMP_CYC = (DUMP_NS * CLK_MHZ + 999) / 1000;
	localparam int STEP_ZC = 2;
	localparam int MARGIN_SHIFT = 6;
	localparam logic [15:0] TRIM_STEP = 16'h0010;
	localparam logic [15:0] TRIM_MAX = 16'h0400;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [1:0] SKIP_HALVES = 2'h2;

	typedef enum logic [2:0] {
		IDLE = 3'h0,
		STEP1 = 3'h1,
		STEP2 = 3'h3,
		STEP3 = 3'h2,
		STEP4 = 3'h6,
		RUN = 3'h7,
		PAUSE = 3'h5
	} seq_t;
endpackage

// ==== hdl/pwm_if.sv ====
interface pwm_if;
	logic en;
	logic kill;
	logic [15:0] period;
	logic [7:0] dead;
	logic hi;
	logic lo;
	logic toff;

	modport ctrl(output en, output kill, output period, output dead,
		input hi, input lo, input toff);
	modport gen(input en, input kill, input period, input dead,
		output hi, output lo, output toff);
endinterface

// ==== hdl/pwm_gen.sv ====
module pwm_gen (
	input wire logic clk_i,
	input wire logic resetn_i,
	pwm_if.gen pw
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [15:0] half;
	logic [1:0] supp;
	logic [1:0] next_supp;
	logic hi;
	logic lo;
	logic toff;
	logic next_hi;
	logic next_lo;
	logic next_toff;
	logic bound;

	always_comb begin
		half = {1'b0, pw.period[15:1]};
		bound = (cnt == 16'h0000) || (cnt == half);
		next_cnt = (cnt >= pw.period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
		next_supp = supp;
		// a kill blanks the rest of this half and the whole next one
		if (pw.kill) begin
			next_supp = llc_pkg::SKIP_HALVES;
		end else if (bound && supp != 2'h0) begin
			next_supp = supp - 2'h1;
		end
		next_hi = cnt >= {8'h00, pw.dead} && cnt < half;
		next_lo = cnt >= half + {8'h00, pw.dead} && cnt < pw.period;
		if (!pw.en) begin
			next_cnt = 16'h0000;
			next_supp = 2'h0;
		end
		if (!pw.en || pw.kill || next_supp != 2'h0) begin
			next_hi = 1'b0;
			next_lo = 1'b0;
		end
		next_toff = (hi && !next_hi) || (lo && !next_lo);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt <= 16'h0000;
			supp <= 2'h0;
			hi <= 1'b0;
			lo <= 1'b0;
			toff <= 1'b0;
		end else begin
			cnt <= next_cnt;
			supp <= next_supp;
			hi <= next_hi;
			lo <= next_lo;
			toff <= next_toff;
		end
	end

	assign pw.hi = hi;
	assign pw.lo = lo;
	assign pw.toff = toff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	no_overlap_a: assert property (!(hi && lo))
		else $error("both switches of one leg on");
	kill_blank_a: assert property (pw.kill |=> (!hi && !lo) [*2])
		else $error("switch on right after a kill");
endmodule

// ==== testbench/tank_model.sv ====
module tank_model (
	input wire logic clk_i,
	input wire logic [1:0] hi_i,
	input wire logic [1:0] lo_i,
	input wire logic [7:0] lag_i,
	output logic [1:0] tank_pos_o,
	output logic [15:0] flips_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] prev_hi;
	logic [1:0] prev_lo;
	logic [1:0] armed;
	logic [1:0][7:0] cnt;
	initial begin
		tank_pos_o = 2'h0;
		flips_o = 16'h0000;
		prev_hi = 2'h0;
		prev_lo = 2'h0;
		armed = 2'h0;
		cnt = '0;
	end
	// current reverses lag_i + 2 clocks after a gate turns off; a lag more than 3 clocks
	// below the dead time means the current leads, i.e. capacitive operation
	always @(posedge clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if ((prev_hi[i] && !hi_i[i]) || (prev_lo[i] && !lo_i[i])) begin
				armed[i] <= 1'b1;
				cnt[i] <= lag_i;
			end else if (armed[i] && cnt[i] == 8'h00) begin
				armed[i] <= 1'b0;
				tank_pos_o[i] <= !tank_pos_o[i];
				if (i == 0) begin
					flips_o <= flips_o + 16'h0001;
				end
			end else if (armed[i]) begin
				cnt[i] <= cnt[i] - 8'h01;
			end
		end
		prev_hi <= hi_i;
		prev_lo <= lo_i;
	end
endmodule

// ==== testbench/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic resetn_i, start_i, load_valid_i;
	logic [11:0] load_i, shed_thr_i, burst_thr_i, dump_slope_i;
	logic [1:0][15:0] period_i;
	logic [7:0] dead_i;
	logic [7:0] lag;
	logic [1:0] tank_pos_i, gate_hi_o, gate_lo_o;
	logic sr_dump_o, phase2_on_o, running_o, cap_fault_o;
	logic [15:0] flips;
	int mismatches = 0;
	int checks_done = 0;

	initial begin
		forever #4 clk_i = !clk_i;
	end

	llc_guard u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i),
		.load_i(load_i), .load_valid_i(load_valid_i),
		.shed_thr_i(shed_thr_i), .burst_thr_i(burst_thr_i),
		.dump_slope_i(dump_slope_i), .period_i(period_i), .dead_i(dead_i),
		.tank_pos_i(tank_pos_i), .gate_hi_o(gate_hi_o),
		.gate_lo_o(gate_lo_o), .sr_dump_o(sr_dump_o),
		.phase2_on_o(phase2_on_o), .running_o(running_o),
		.cap_fault_o(cap_fault_o));

	tank_model u_tank (.clk_i(clk_i), .hi_i(gate_hi_o), .lo_i(gate_lo_o),
		.lag_i(lag), .tank_pos_o(tank_pos_i), .flips_o(flips));

	task automatic report_and_stop();
		if (mismatches == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic sample(input logic [11:0] v);
		load_i = v;
		load_valid_i = 1'b1;
		tick(1);
		load_valid_i = 1'b0;
	endtask

	// bounded wait for regulation; returns the crossings seen meanwhile
	task automatic wait_run(output logic [15:0] n);
		logic [15:0] f0;
		int k;
		f0 = flips;
		k = 0;
		while (running_o !== 1'b1 && k < 20000) begin
			tick(1);
			k++;
		end
		n = flips - f0;
	endtask

	task automatic t_start();
		logic [15:0] n;
		chk({gate_hi_o, gate_lo_o, sr_dump_o, phase2_on_o, running_o,
			cap_fault_o}, 16'h0000);
		start_i = 1'b1;
		wait_run(n);
		chk(running_o, 1'b1);
		chk(n >= 16'h0008, 1'b1);
	endtask

	task automatic t_phases();
		int r0, r1;
		logic [1:0] ph;
		r0 = 0;
		r1 = 0;
		sample(12'h7D0);
		tick(1);
		chk(phase2_on_o, 1'b1);
		ph = gate_hi_o;
		repeat (2400) begin
			tick(1);
			r0 += int'(gate_hi_o[0] && !ph[0]);
			r1 += int'(gate_hi_o[1] && !ph[1]);
			ph = gate_hi_o;
		end
		// phase 1 runs a longer period, so it must pulse less often
		chk(r0 > r1 && r1 > 0, 1'b1);
	endtask

	task automatic t_dump();
		sample(12'h5DC);
		tick(1);
		chk(sr_dump_o, 1'b1);
		tick(1190);
		chk(sr_dump_o, 1'b1);
		tick(100);
		chk(sr_dump_o, 1'b0);
	endtask

	task automatic t_shed();
		sample(12'h1F4);
		tick(1);
		chk(phase2_on_o, 1'b0);
		tick(600);
		chk({gate_hi_o[1], gate_lo_o[1]}, 2'h0);
		chk(running_o, 1'b1);
	endtask

	task automatic t_burst();
		logic [15:0] f0;
		sample(12'h032);
		tick(600);
		chk({gate_hi_o, gate_lo_o}, 4'h0);
		f0 = flips;
		sample(12'h7D0);
		tick(600);
		chk(flips != f0, 1'b1);
		chk(phase2_on_o, 1'b1);
	endtask

	// ticks until the next rising edge of the phase 0 high-side gate
	task automatic next_rise(output int n);
		logic p;
		n = 0;
		do begin
			p = gate_hi_o[0];
			tick(1);
			n++;
		end while (!(gate_hi_o[0] && !p) && n < 400);
	endtask

	// a lag of 0x11 puts the reversal right at the dead time edge, so the
	// measured phase reads zero; the window is short so trim stays small
	task automatic t_trim();
		int n;
		lag = 8'h11;
		tick(210);
		lag = 8'h28;
		next_rise(n);
		next_rise(n);
		next_rise(n);
		chk(n < 200, 1'b1);
		chk(cap_fault_o, 1'b0);
	endtask

	task automatic t_cap();
		logic [15:0] n;
		logic [3:0] seen;
		int k;
		k = 0;
		seen = 4'h0;
		lag = 8'h00;
		while (cap_fault_o !== 1'b1 && k < 2000) begin
			tick(1);
			k++;
		end
		chk(cap_fault_o, 1'b1);
		lag = 8'h28;
		repeat (2400) begin
			tick(1);
			seen |= {gate_hi_o, gate_lo_o};
		end
		chk(seen, 4'h0);
		chk(cap_fault_o, 1'b1);
		tick(150);
		chk({cap_fault_o, running_o}, 2'h0);
		wait_run(n);
		chk(n >= 16'h0008, 1'b1);
	endtask

	initial begin
		resetn_i = 1'b0;
		start_i = 1'b0;
		load_i = 12'h000;
		load_valid_i = 1'b0;
		shed_thr_i = 12'h3E8;
		burst_thr_i = 12'h064;
		dump_slope_i = 12'h12C;
		period_i = {16'h00F0, 16'h00C8};
		dead_i = 8'h14;
		lag = 8'h28;
		tick(6);
		resetn_i = 1'b1;
		t_start();
		t_phases();
		t_dump();
		t_shed();
		t_burst();
		t_trim();
		t_cap();
		report_and_stop();
	end

	initial begin
		repeat (80000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
endmodule
